// >>> design/vst_pkg.sv
package vst_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] OFS_CMD_PORT   = 8'h00;
  localparam logic [7:0] OFS_TOP_FIXED  = 8'h04;
  localparam logic [7:0] OFS_SCROLL_HT  = 8'h08;
  localparam logic [7:0] OFS_BOT_FIXED  = 8'h0C;
  localparam logic [7:0] OFS_SCROLL_ST  = 8'h10;
  localparam logic [7:0] OFS_ACCESS_CTL = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;

  // command port fields
  localparam int CMD_BYTE_MSB = 7;
  localparam int CMD_DC_BIT   = 8;

  // status register fields
  localparam int ST_TEAR_EN   = 0;
  localparam int ST_TEAR_MODE = 1;
  localparam int ST_SCROLL    = 2;
  localparam int ST_PARTIAL   = 3;
  localparam int ST_SLEEP     = 4;

  // command codes
  localparam logic [7:0] CMD_SW_RESET     = 8'h01;
  localparam logic [7:0] CMD_SLEEP_IN     = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT    = 8'h11;
  localparam logic [7:0] CMD_PARTIAL_DISP = 8'h12;
  localparam logic [7:0] CMD_NORMAL_DISP  = 8'h13;
  localparam logic [7:0] CMD_SCROLL_DEF   = 8'h33;
  localparam logic [7:0] CMD_TEAR_OFF     = 8'h34;
  localparam logic [7:0] CMD_TEAR_ON      = 8'h35;
  localparam logic [7:0] CMD_ACCESS_CTL   = 8'h36;
  localparam logic [7:0] CMD_SCROLL_START = 8'h37;
  localparam logic [7:0] CMD_NONE         = 8'h00;

  // parameter byte indices
  localparam logic [2:0] PIX_0 = 3'h0;
  localparam logic [2:0] PIX_1 = 3'h1;
  localparam logic [2:0] PIX_3 = 3'h3;
  localparam logic [2:0] PIX_5 = 3'h5;
  localparam logic [2:0] PIX_MAX = 3'h7;

  // field positions
  localparam int ORDER_BIT     = 4;
  localparam int TEAR_MODE_BIT = 0;

  // reset values
  localparam logic [15:0] RST_TOP_FIXED  = 16'h0000;
  localparam logic [15:0] RST_SCROLL_HT  = 16'h0140;
  localparam logic [15:0] RST_BOT_FIXED  = 16'h0000;
  localparam logic [15:0] RST_SCROLL_ST  = 16'h0000;
  localparam logic [7:0]  RST_ACCESS_CTL = 8'h00;

  localparam logic [15:0] ONE_LINE = 16'h0001;

endpackage : vst_pkg

// >>> design/vst_top.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps

module vst_top #(
  parameter int          ADDR_W = 8,
  parameter logic [15:0] LINES  = 16'h0140
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              vblank,
  input  wire logic              hblank,
  output logic                   tear_indication_out,
  output logic      [15:0]       scroll_begin_line,
  output logic      [15:0]       first_scroll_line,
  output logic                   scroll_step_down
);

  // apb state
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        err_out_ff;

  // command interpreter state
  logic [7:0]  cur_cmd_ff;
  logic [2:0]  param_idx_ff;
  logic [7:0]  hi_byte_ff;

  // held settings
  logic [15:0] top_fixed_lines_ff;
  logic [15:0] scroll_area_height_ff;
  logic [15:0] bottom_fixed_lines_ff;
  logic [15:0] scroll_start_ff;
  logic [7:0]  memory_access_control_ff;
  logic        tear_en_ff;
  logic        tear_mode_ff;
  logic        scroll_mode_ff;
  logic        partial_ff;
  logic        sleep_ff;

  // registered outputs toward the panel
  logic        tear_out_ff;
  logic [15:0] scroll_begin_ff;
  logic [15:0] first_line_ff;
  logic        step_down_ff;

  // bus decode
  wire logic [7:0] addr_b;
  wire logic       setup_ph;
  wire logic       done_ph;
  wire logic       hit_cmd;
  wire logic       hit_top;
  wire logic       hit_ht;
  wire logic       hit_bot;
  wire logic       hit_st;
  wire logic       hit_acc;
  wire logic       hit_stat;
  wire logic       mapped;
  wire logic       byte_wr;

  assign addr_b   = 8'(paddr);
  assign setup_ph = psel & ~penable;
  assign done_ph  = psel & penable & pready_ff;
  assign hit_cmd  = (addr_b == vst_pkg::OFS_CMD_PORT);
  assign hit_top  = (addr_b == vst_pkg::OFS_TOP_FIXED);
  assign hit_ht   = (addr_b == vst_pkg::OFS_SCROLL_HT);
  assign hit_bot  = (addr_b == vst_pkg::OFS_BOT_FIXED);
  assign hit_st   = (addr_b == vst_pkg::OFS_SCROLL_ST);
  assign hit_acc  = (addr_b == vst_pkg::OFS_ACCESS_CTL);
  assign hit_stat = (addr_b == vst_pkg::OFS_STATUS);
  assign mapped   = hit_cmd | hit_top | hit_ht | hit_bot
                  | hit_st | hit_acc | hit_stat;

  // a byte enters only when both low lanes are enabled, so the select bit is defined
  assign byte_wr = done_ph & pwrite & hit_cmd & pstrb[0] & pstrb[1] & ~pslverr_ff;

  // the byte stream
  wire logic [7:0] in_byte;
  wire logic       in_dc;
  wire logic       cmd_stb;
  wire logic       par_stb;

  assign in_byte = pwdata[vst_pkg::CMD_BYTE_MSB:0];
  assign in_dc   = pwdata[vst_pkg::CMD_DC_BIT];
  assign cmd_stb = byte_wr & ~in_dc;
  assign par_stb = byte_wr & in_dc;

  // command decode, one wire per code that takes no parameter
  wire logic is_swrst;
  wire logic is_slp_in;
  wire logic is_slp_out;
  wire logic is_partial;
  wire logic is_normal;
  wire logic is_tear_off;

  assign is_swrst    = cmd_stb & (in_byte == vst_pkg::CMD_SW_RESET);
  assign is_slp_in   = cmd_stb & (in_byte == vst_pkg::CMD_SLEEP_IN);
  assign is_slp_out  = cmd_stb & (in_byte == vst_pkg::CMD_SLEEP_OUT);
  assign is_partial  = cmd_stb & (in_byte == vst_pkg::CMD_PARTIAL_DISP);
  assign is_normal   = cmd_stb & (in_byte == vst_pkg::CMD_NORMAL_DISP);
  assign is_tear_off = cmd_stb & (in_byte == vst_pkg::CMD_TEAR_OFF);

  // parameter decode against the open command
  wire logic in_def;
  wire logic in_ton;
  wire logic in_acc;
  wire logic in_vsp;
  wire logic [15:0] word16;

  assign in_def = par_stb & (cur_cmd_ff == vst_pkg::CMD_SCROLL_DEF);
  assign in_ton = par_stb & (cur_cmd_ff == vst_pkg::CMD_TEAR_ON);
  assign in_acc = par_stb & (cur_cmd_ff == vst_pkg::CMD_ACCESS_CTL);
  assign in_vsp = par_stb & (cur_cmd_ff == vst_pkg::CMD_SCROLL_START);
  assign word16 = {hi_byte_ff, in_byte};

  // each 16-bit field commits only on its low byte
  wire logic wr_top;
  wire logic wr_ht;
  wire logic wr_bot;
  wire logic wr_vsp;
  wire logic wr_ton;

  assign wr_top = in_def & (param_idx_ff == vst_pkg::PIX_1);
  assign wr_ht  = in_def & (param_idx_ff == vst_pkg::PIX_3);
  assign wr_bot = in_def & (param_idx_ff == vst_pkg::PIX_5);
  assign wr_vsp = in_vsp & (param_idx_ff == vst_pkg::PIX_1) & ~partial_ff;
  assign wr_ton = in_ton & (param_idx_ff == vst_pkg::PIX_0) & ~tear_en_ff;

  // apb answer: one wait state, then pready for one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
    end
  end

  // error pin rises with pready from a flop of its own, so no gate sits on the output
  always_ff @(posedge clk) begin
    if (reset) begin
      err_out_ff <= 1'b0;
    end else begin
      err_out_ff <= psel & penable & ~pready_ff & pslverr_ff;
    end
  end

  // read data and error are fixed in the setup cycle while the address is stable
  wire logic [31:0] rd_mux;
  wire logic [31:0] stat_word;

  assign stat_word = 32'(({sleep_ff, partial_ff, scroll_mode_ff, tear_mode_ff, tear_en_ff})
                     << vst_pkg::ST_TEAR_EN);
  assign rd_mux = hit_cmd  ? 32'(cur_cmd_ff) :
                  hit_top  ? 32'(top_fixed_lines_ff) :
                  hit_ht   ? 32'(scroll_area_height_ff) :
                  hit_bot  ? 32'(bottom_fixed_lines_ff) :
                  hit_st   ? 32'(scroll_start_ff) :
                  hit_acc  ? 32'(memory_access_control_ff) :
                  hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= ~mapped;
    end
  end

  // command and parameter tracking; a new command byte restarts the count
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_cmd_ff   <= vst_pkg::CMD_NONE;
      param_idx_ff <= vst_pkg::PIX_0;
      hi_byte_ff   <= 8'h00;
    end else if (cmd_stb) begin
      cur_cmd_ff   <= in_byte;
      param_idx_ff <= vst_pkg::PIX_0;
    end else if (par_stb) begin
      hi_byte_ff   <= in_byte;
      if (param_idx_ff != vst_pkg::PIX_MAX) begin
        param_idx_ff <= param_idx_ff + 3'h1;
      end
    end
  end

  // scroll definition; soft reset restores the same defaults as hard reset
  always_ff @(posedge clk) begin
    if (reset || is_swrst) begin
      top_fixed_lines_ff    <= vst_pkg::RST_TOP_FIXED;
      scroll_area_height_ff <= vst_pkg::RST_SCROLL_HT;
      bottom_fixed_lines_ff <= vst_pkg::RST_BOT_FIXED;
    end else begin
      if (wr_top) top_fixed_lines_ff    <= word16;
      if (wr_ht)  scroll_area_height_ff <= word16;
      if (wr_bot) bottom_fixed_lines_ff <= word16;
    end
  end

  // scroll start pointer and scroll mode
  always_ff @(posedge clk) begin
    if (reset || is_swrst) begin
      scroll_start_ff <= vst_pkg::RST_SCROLL_ST;
      scroll_mode_ff  <= 1'b0;
    end else if (is_normal || is_partial) begin
      scroll_mode_ff  <= 1'b0;
    end else if (wr_vsp) begin
      scroll_start_ff <= word16;
      scroll_mode_ff  <= 1'b1;
    end
  end

  // access control byte survives soft reset
  always_ff @(posedge clk) begin
    if (reset) begin
      memory_access_control_ff <= vst_pkg::RST_ACCESS_CTL;
    end else if (in_acc && param_idx_ff == vst_pkg::PIX_0) begin
      memory_access_control_ff <= in_byte;
    end
  end

  // display modes: partial/normal and sleep
  always_ff @(posedge clk) begin
    if (reset || is_swrst) begin
      partial_ff <= 1'b0;
      sleep_ff   <= 1'b1;
    end else begin
      if (is_partial) partial_ff <= 1'b1;
      if (is_normal)  partial_ff <= 1'b0;
      if (is_slp_in)  sleep_ff   <= 1'b1;
      if (is_slp_out) sleep_ff   <= 1'b0;
    end
  end

  // tear enable and mode; off while off and on while on leave state alone
  always_ff @(posedge clk) begin
    if (reset || is_swrst) begin
      tear_en_ff   <= 1'b0;
      tear_mode_ff <= 1'b0;
    end else if (is_tear_off) begin
      tear_en_ff   <= 1'b0;
    end else if (wr_ton) begin
      tear_en_ff   <= 1'b1;
      tear_mode_ff <= in_byte[vst_pkg::TEAR_MODE_BIT];
    end
  end

  // tear pin: refresh order is deliberately not an input to this term
  wire logic tear_src;

  assign tear_src = vblank | (tear_mode_ff & hblank);

  always_ff @(posedge clk) begin
    if (reset) begin
      tear_out_ff <= 1'b0;
    end else begin
      tear_out_ff <= tear_en_ff & ~sleep_ff & tear_src;
    end
  end

  // scroll geometry for the line fetch logic, in frame memory line pointers
  wire logic        order;
  wire logic [15:0] last_line;
  wire logic [15:0] begin_line;

  assign order      = memory_access_control_ff[vst_pkg::ORDER_BIT];
  assign last_line  = LINES - vst_pkg::ONE_LINE;
  // order 0 counts the top area up from line 0, order 1 down from the last line
  assign begin_line = order ? (last_line - top_fixed_lines_ff)
                            : top_fixed_lines_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      scroll_begin_ff <= vst_pkg::RST_TOP_FIXED;
      first_line_ff   <= vst_pkg::RST_SCROLL_ST;
      step_down_ff    <= 1'b0;
    end else begin
      scroll_begin_ff <= begin_line;
      first_line_ff   <= scroll_start_ff;
      step_down_ff    <= order;
    end
  end

  // outputs straight from flops
  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = err_out_ff;
  assign tear_indication_out = tear_out_ff;
  assign scroll_begin_line   = scroll_begin_ff;
  assign first_scroll_line   = first_line_ff;
  assign scroll_step_down    = step_down_ff;

endmodule : vst_top

// >>> tb/vst_props.sv
`timescale 1ns/10ps
module vst_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              vblank,
  input wire logic              hblank,
  input wire logic              tear_indication_out,
  input wire logic [15:0]       scroll_begin_line,
  input wire logic [15:0]       first_scroll_line,
  input wire logic              scroll_step_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a transfer is a setup cycle, one wait state, then the answer
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  property p_ready_wait; s_setup |=> s_answer; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("late or early pready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without pready");
  property p_rdata; $changed(prdata) |-> $past(psel && !penable); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved outside setup");
  // tear pin only rises after a blanking cause one edge earlier
  property p_tear; tear_indication_out |-> $past(vblank) || $past(hblank); endproperty
  a_tear: assert property (p_tear) else $error("tear high without blanking");
  property p_reset;
    $past(reset) |-> !tear_indication_out && !scroll_step_down
      && scroll_begin_line == 16'h0000 && first_scroll_line == 16'h0000;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  // geometry only moves two edges after an accepted write
  property p_geom;
    $changed(first_scroll_line) || $changed(scroll_begin_line) || $changed(scroll_step_down)
      |-> $past(pready && pwrite, 2);
  endproperty
  a_geom: assert property (p_geom) else $error("geometry moved without a write");
endmodule : vst_props

bind vst_top vst_props #(.ADDR_W(ADDR_W)) u_props (.clk, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .vblank, .hblank,
  .tear_indication_out, .scroll_begin_line, .first_scroll_line, .scroll_step_down);

// >>> tb/vst_panel_model.sv
`timescale 1ns/10ps
module vst_panel_model #(
  parameter int H_LEN   = 8,
  parameter int V_LINES = 6
) (
  input wire logic clk,
  input wire logic reset,
  output logic     vblank,
  output logic     hblank
);
  logic [7:0] h_ff;
  logic [7:0] v_ff;
  // short lines and frames keep blanking frequent in a short run
  always_ff @(posedge clk) begin
    if (reset || h_ff == 8'(H_LEN - 1)) begin
      h_ff <= 8'h00;
    end else begin
      h_ff <= h_ff + 8'h01;
    end
    if (reset || (h_ff == 8'(H_LEN - 1) && v_ff == 8'(V_LINES - 1))) begin
      v_ff <= 8'h00;
    end else if (h_ff == 8'(H_LEN - 1)) begin
      v_ff <= v_ff + 8'h01;
    end
  end
  // blanking sits at the end of each line and of each frame
  assign hblank = (h_ff >= 8'(H_LEN - 2));
  assign vblank = (v_ff == 8'(V_LINES - 1));
endmodule : vst_panel_model

// >>> tb/vertical_scroll_and_tear_signal_cmds_bench.sv
`timescale 1ns/10ps
module vertical_scroll_and_tear_signal_cmds_bench;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        vblank;
  logic        hblank;
  logic        tear_indication_out;
  logic [15:0] scroll_begin_line;
  logic [15:0] first_scroll_line;
  logic        scroll_step_down;
  logic [31:0] rd;
  logic        er;
  int          miscompares = 0;
  int          n_checks = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  vst_top dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .vblank, .hblank, .tear_indication_out, .scroll_begin_line,
    .first_scroll_line, .scroll_step_down);
  vst_panel_model panel_u (.clk, .reset, .vblank, .hblank);
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one transfer, held until pready is sampled; an idle cycle follows
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic cmd(input logic [7:0] b);
    apb(1'h1, vst_pkg::OFS_CMD_PORT, {24'h0, b});
  endtask : cmd
  task automatic par(input logic [7:0] b);
    apb(1'h1, vst_pkg::OFS_CMD_PORT, {23'h0, 1'h1, b});
  endtask : par
  // six parameter bytes, high byte of each field first
  task automatic def(input logic [47:0] v);
    for (int i = 5; i >= 0; i--) begin
      par(v[i*8+:8]);
    end
  endtask : def
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk
  // find a cycle with the given blanking, judge the pin one edge later
  task automatic tear_at(input logic v, input logic h, input logic e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(vblank === v && hblank === h) && n < 200);
    if (!(vblank === v && hblank === h)) begin
      miscompares++;
      test_done();
    end
    @(posedge clk);
    chk("tear", {31'h0, e}, {31'h0, tear_indication_out});
  endtask : tear_at
  task automatic t_reset;
    rchk("top", vst_pkg::OFS_TOP_FIXED, 32'h0);
    rchk("height", vst_pkg::OFS_SCROLL_HT, 32'h140);
    rchk("bottom", vst_pkg::OFS_BOT_FIXED, 32'h0);
    rchk("status", vst_pkg::OFS_STATUS, 32'h10);
    rchk("access", vst_pkg::OFS_ACCESS_CTL, 32'h0);
    tear_at(1'h1, 1'h0, 1'h0);
    apb(1'h0, 8'h1C, 32'h0);
    chk("error", 32'h1, {31'h0, er});
    $display("test reset done");
  endtask : t_reset
  task automatic t_scroll;
    cmd(vst_pkg::CMD_SCROLL_DEF);
    def(48'h0010_0120_0008);
    rchk("top", vst_pkg::OFS_TOP_FIXED, 32'h10);
    rchk("height", vst_pkg::OFS_SCROLL_HT, 32'h120);
    rchk("bottom", vst_pkg::OFS_BOT_FIXED, 32'h8);
    chk("begin", 32'h10, {16'h0, scroll_begin_line});
    cmd(vst_pkg::CMD_ACCESS_CTL);
    par(8'h10);
    @(posedge clk);
    chk("step", 32'h1, {31'h0, scroll_step_down});
    chk("begin", 32'h12F, {16'h0, scroll_begin_line});
    cmd(vst_pkg::CMD_SCROLL_START);
    par(8'h00);
    par(8'h05);
    rchk("status", vst_pkg::OFS_STATUS, 32'h14);
    chk("first", 32'h5, {16'h0, first_scroll_line});
    cmd(vst_pkg::CMD_PARTIAL_DISP);
    rchk("status", vst_pkg::OFS_STATUS, 32'h18);
    cmd(vst_pkg::CMD_SCROLL_START);
    par(8'h00);
    par(8'h09);
    rchk("status", vst_pkg::OFS_STATUS, 32'h18);
    chk("first", 32'h5, {16'h0, first_scroll_line});
    rchk("start", vst_pkg::OFS_SCROLL_ST, 32'h5);
    cmd(vst_pkg::CMD_SCROLL_DEF);
    def(48'h0001_0100_0002);
    rchk("top", vst_pkg::OFS_TOP_FIXED, 32'h1);
    chk("begin", 32'h13E, {16'h0, scroll_begin_line});
    cmd(vst_pkg::CMD_NORMAL_DISP);
    rchk("status", vst_pkg::OFS_STATUS, 32'h10);
    rchk("command", vst_pkg::OFS_CMD_PORT, 32'h13);
    cmd(vst_pkg::CMD_SCROLL_DEF);
    par(8'h00);
    par(8'h22);
    par(8'h01);
    cmd(vst_pkg::CMD_NORMAL_DISP);
    rchk("top", vst_pkg::OFS_TOP_FIXED, 32'h22);
    rchk("height", vst_pkg::OFS_SCROLL_HT, 32'h100);
    $display("test scroll done");
  endtask : t_scroll
  task automatic t_tear;
    cmd(vst_pkg::CMD_SLEEP_OUT);
    cmd(vst_pkg::CMD_TEAR_ON);
    par(8'h00);
    rchk("status", vst_pkg::OFS_STATUS, 32'h1);
    tear_at(1'h0, 1'h1, 1'h0);
    tear_at(1'h1, 1'h0, 1'h1);
    cmd(vst_pkg::CMD_TEAR_ON);
    par(8'h01);
    rchk("status", vst_pkg::OFS_STATUS, 32'h1);
    cmd(vst_pkg::CMD_ACCESS_CTL);
    par(8'h00);
    tear_at(1'h1, 1'h0, 1'h1);
    // a command byte without both low lanes enabled must be dropped
    pstrb <= 4'h1;
    cmd(vst_pkg::CMD_TEAR_OFF);
    pstrb <= 4'hF;
    rchk("status", vst_pkg::OFS_STATUS, 32'h1);
    cmd(vst_pkg::CMD_TEAR_OFF);
    rchk("status", vst_pkg::OFS_STATUS, 32'h0);
    tear_at(1'h1, 1'h0, 1'h0);
    cmd(vst_pkg::CMD_TEAR_OFF);
    rchk("status", vst_pkg::OFS_STATUS, 32'h0);
    cmd(vst_pkg::CMD_TEAR_ON);
    par(8'h01);
    tear_at(1'h0, 1'h1, 1'h1);
    cmd(vst_pkg::CMD_SLEEP_IN);
    rchk("status", vst_pkg::OFS_STATUS, 32'h13);
    tear_at(1'h1, 1'h0, 1'h0);
    $display("test tear done");
  endtask : t_tear
  task automatic t_swreset;
    cmd(vst_pkg::CMD_ACCESS_CTL);
    par(8'h10);
    cmd(vst_pkg::CMD_SW_RESET);
    rchk("top", vst_pkg::OFS_TOP_FIXED, 32'h0);
    rchk("height", vst_pkg::OFS_SCROLL_HT, 32'h140);
    rchk("bottom", vst_pkg::OFS_BOT_FIXED, 32'h0);
    rchk("status", vst_pkg::OFS_STATUS, 32'h10);
    rchk("access", vst_pkg::OFS_ACCESS_CTL, 32'h10);
    tear_at(1'h1, 1'h0, 1'h0);
    $display("test soft reset done");
  endtask : t_swreset
  // reset for ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_scroll();
    t_tear();
    t_swreset();
    test_done();
  end
endmodule : vertical_scroll_and_tear_signal_cmds_bench
